// file: hw/dscs_chan_store.sv
// Per-channel store of the last written command and reference words.
`timescale 1ns/1ps
module dscs_chan_store
    import dscs_pkg::*;
#(
    parameter int N_CH  = NUM_CH,
    parameter int N_PAR = NUM_PAR
) (
    input logic              pclk,
    input logic              presetn,
    dscs_chan_if.store       bus
);

    typedef struct packed {
        logic [N_CH-1:0][N_PAR-1:0][WORD_W-1:0] word;
    } dscs_store_t;

    dscs_store_t s_q;
    dscs_store_t s_d;

    // Out-of-range selects read as zero so a stray code never aliases a channel.
    function automatic logic [15:0] pick(input dscs_store_t s, input logic [2:0] ch,
                                         input logic [2:0] par);
        if (int'(ch) < N_CH && int'(par) < N_PAR) begin
            return s.word[ch][par];
        end
        return 16'h0000;
    endfunction : pick

    always_comb begin
        s_d = s_q;
        if (bus.wr_en && int'(bus.wr_ch) < N_CH && int'(bus.wr_par) < N_PAR) begin
            s_d.word[bus.wr_ch][bus.wr_par] = bus.wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.rd_data = pick(s_q, bus.rd_ch, bus.rd_par);
    assign bus.act_cmd = pick(s_q, bus.cmd_ch, PAR_CMD);
    assign bus.act_spd = pick(s_q, bus.ref_ch, PAR_SPD);
    assign bus.act_frq = pick(s_q, bus.ref_ch, PAR_FRQ);
    assign bus.act_ext = pick(s_q, bus.cmd_ch, PAR_EXT);
    assign bus.act_pid = pick(s_q, bus.ref_ch, PAR_PID);
    assign bus.act_mul = pick(s_q, bus.ref_ch, PAR_MUL);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_store_write_back: assert property (
        (bus.wr_en && bus.wr_ch == bus.rd_ch && bus.wr_par == bus.rd_par && bus.wr_ch < 3'h6
         && bus.wr_par < 3'h6) ##1 ($stable(bus.rd_ch) && $stable(bus.rd_par))
        |-> bus.rd_data == $past(bus.wr_data))
        else $error("Channel word not kept after write.");

endmodule : dscs_chan_store

// file: hw/dscs_top.sv
// Drive start sequencer with command and reference channel selection behind APB.
`timescale 1ns/1ps
// Overview of operation
// - Enable operation from ready goes directly.
// - Motor runs only with nonzero reference.
// - Shutdown reaches ready without power supply.
// - Voltage bit shows supply; 21 or 31.
// - Supply absent in switched on past timeout gives mains fault.
// - Switch-on closes line contactor when configured.
// - Six source channels are supported.
// - Both Modbus ports form one channel.
// - Channels chosen by configuration or switching.
// - Only control and references are switched.
// - Last value per channel stays readable.
// - Combined mode uses one channel for both.
// - Split mode allows different channels.
// - I/O profile always works split.
// - Combined switch moves command and reference.
// - Split switches act independently.
// - Status masked by 6F identifies state.
module dscs_top
    import dscs_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_TICK_CYC
) (
    input  logic        pclk,
    input  logic        presetn,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [11:0] paddr,
    input  logic [31:0] pwdata,
    output logic        pready,
    output logic [31:0] prdata,
    output logic        pslverr,
    input  logic        supply_present,
    input  logic        term_cmd_switch,
    input  logic        term_ref_switch,
    output logic        line_contactor_close,
    output logic        motor_run
);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [15:0]       timeout;
        dscs_state_t       state;
        logic [15:0]       status;
        logic [7:0]        fault_code;
        logic [15:0]       tick_cnt;
        logic [15:0]       loss_ms;
        logic              freset_prev;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic              contactor;
        logic              run;
    } dscs_regs_t;

    dscs_regs_t  s_q;
    dscs_regs_t  s_d;
    dscs_chan_if chan ();

    logic        setup;
    logic        access;
    logic        chan_hit;
    logic        tick;
    logic        sw_cmd;
    logic        sw_ref;
    logic        split;
    logic [2:0]  ref_sel;
    logic [2:0]  cmd_sel;
    logic [15:0] cw;
    logic        ref_nonzero;
    logic        loss_expired;
    logic [31:0] rd_word;
    logic        rd_ok;

    function automatic logic is_shutdown(input logic [15:0] w);
        return w[CW_EN_VOLT] && w[CW_QSTOP] && !w[CW_SWITCH_ON];
    endfunction : is_shutdown

    function automatic logic is_switch_on(input logic [15:0] w);
        return w[CW_EN_VOLT] && w[CW_QSTOP] && w[CW_SWITCH_ON] && !w[CW_EN_OP];
    endfunction : is_switch_on

    function automatic logic is_enable(input logic [15:0] w);
        return w[CW_EN_VOLT] && w[CW_QSTOP] && w[CW_SWITCH_ON] && w[CW_EN_OP];
    endfunction : is_enable

    // Quick stop is folded into disable voltage; there is no quick stop active state.
    function automatic logic is_disable(input logic [15:0] w);
        return !w[CW_EN_VOLT] || !w[CW_QSTOP];
    endfunction : is_disable

    function automatic logic [15:0] status_of(input dscs_state_t st, input logic volt);
        logic [15:0] w;
        w = 16'h0000;
        w[SW_VOLT] = volt;
        case (st)
            ST_SW_DIS: w[SW_SWDIS] = 1'b1;
            ST_READY: begin
                w[SW_QSTOP] = 1'b1;
                w[SW_READY] = 1'b1;
            end
            ST_SW_ON: begin
                w[SW_QSTOP] = 1'b1;
                w[SW_SWON]  = 1'b1;
                w[SW_READY] = 1'b1;
            end
            ST_OP_EN: begin
                w[SW_QSTOP] = 1'b1;
                w[SW_OPEN]  = 1'b1;
                w[SW_SWON]  = 1'b1;
                w[SW_READY] = 1'b1;
            end
            ST_FAULT: w[SW_FAULT] = 1'b1;
            default: w[SW_VOLT] = volt;
        endcase
        return w;
    endfunction : status_of

    assign setup  = psel && !penable;
    assign access = psel && penable && s_q.pready;
    assign chan_hit = paddr[11:8] == CHAN_PAGE && paddr[7:5] <= BLK_MODBUS_P2
                      && paddr[4:2] <= PAR_MUL && paddr[1:0] == 2'h0;

    assign chan.wr_en   = access && pwrite && chan_hit;
    assign chan.wr_ch   = (paddr[7:5] == BLK_MODBUS_P2) ? CH_MODBUS : paddr[7:5];
    assign chan.wr_par  = paddr[4:2];
    assign chan.wr_data = pwdata[15:0];
    assign chan.rd_ch   = chan.wr_ch;
    assign chan.rd_par  = paddr[4:2];

    assign sw_cmd = s_q.ctrl[CTRL_CMD_SW] || term_cmd_switch;
    assign sw_ref = s_q.ctrl[CTRL_REF_SW] || term_ref_switch;
    assign split  = s_q.ctrl[CTRL_PROF+:2] != PROF_COMBINED;
    assign ref_sel = sw_ref ? s_q.ctrl[CTRL_REF2+:3] : s_q.ctrl[CTRL_REF1+:3];
    assign cmd_sel = sw_cmd ? s_q.ctrl[CTRL_CMD2+:3] : s_q.ctrl[CTRL_CMD1+:3];
    assign chan.cmd_ch = split ? cmd_sel : ref_sel;
    assign chan.ref_ch = ref_sel;

    assign cw          = chan.act_cmd;
    assign ref_nonzero = chan.act_frq != 16'h0000 || chan.act_spd != 16'h0000;
    assign tick        = s_q.tick_cnt == 16'(MS_TICK_CYCLES - 1);
    assign loss_expired = s_q.state == ST_SW_ON && !supply_present && s_q.loss_ms >= s_q.timeout;

    always_comb begin
        rd_ok   = 1'b1;
        rd_word = 32'h00000000;
        if (chan_hit) begin
            rd_word = {16'h0000, chan.rd_data};
        end else begin
            case (paddr)
                REG_CTRL:    rd_word = {14'h0000, s_q.ctrl};
                REG_TIMEOUT: rd_word = {16'h0000, s_q.timeout};
                REG_STATUS:  rd_word = {16'h0000, s_q.status};
                REG_FAULT:   rd_word = {24'h000000, s_q.fault_code};
                REG_ACT_CMD: rd_word = {16'h0000, chan.act_cmd};
                REG_ACT_EXT: rd_word = {16'h0000, chan.act_ext};
                REG_ACT_SPD: rd_word = {16'h0000, chan.act_spd};
                REG_ACT_FRQ: rd_word = {16'h0000, chan.act_frq};
                REG_ACT_PID: rd_word = {16'h0000, chan.act_pid};
                REG_ACT_MUL: rd_word = {16'h0000, chan.act_mul};
                REG_ACT_SEL: rd_word = {26'h0000000, chan.ref_ch, chan.cmd_ch};
                default:     rd_ok = 1'b0;
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.pready  = setup;
        s_d.pslverr = 1'b0;
        if (setup) begin
            s_d.prdata  = rd_word;
            // Only the two writable registers and the channel page accept writes.
            s_d.pslverr = !rd_ok || (pwrite && !chan_hit && paddr != REG_CTRL && paddr != REG_TIMEOUT);
        end
        if (access && pwrite && !s_q.pslverr) begin
            if (paddr == REG_CTRL) begin
                s_d.ctrl = pwdata[CTRL_W-1:0];
            end
            if (paddr == REG_TIMEOUT) begin
                s_d.timeout = pwdata[15:0];
            end
        end

        s_d.tick_cnt = tick ? 16'h0000 : s_q.tick_cnt + 16'h0001;
        if (s_q.state != ST_SW_ON || supply_present) begin
            s_d.loss_ms = 16'h0000;
        end else if (tick && s_q.loss_ms != 16'hFFFF) begin
            s_d.loss_ms = s_q.loss_ms + 16'h0001;
        end

        s_d.freset_prev = cw[CW_FRESET];
        case (s_q.state)
            ST_NOT_READY: s_d.state = ST_SW_DIS;
            ST_SW_DIS: begin
                if (is_shutdown(cw)) begin
                    s_d.state = ST_READY;
                end
            end
            ST_READY: begin
                if (is_disable(cw)) begin
                    s_d.state = ST_SW_DIS;
                end else if (is_enable(cw)) begin
                    s_d.state = ST_OP_EN;
                end else if (is_switch_on(cw)) begin
                    s_d.state = ST_SW_ON;
                end
            end
            ST_SW_ON: begin
                if (loss_expired) begin
                    s_d.state      = ST_FAULT;
                    s_d.fault_code = MAINS_LOSS_FAULT;
                end else if (is_disable(cw)) begin
                    s_d.state = ST_SW_DIS;
                end else if (is_shutdown(cw)) begin
                    s_d.state = ST_READY;
                end else if (is_enable(cw)) begin
                    s_d.state = ST_OP_EN;
                end
            end
            ST_OP_EN: begin
                if (is_disable(cw)) begin
                    s_d.state = ST_SW_DIS;
                end else if (is_shutdown(cw)) begin
                    s_d.state = ST_READY;
                end else if (is_switch_on(cw)) begin
                    s_d.state = ST_SW_ON;
                end
            end
            ST_FAULT: begin
                // Reset acts on the rising edge only, so a held bit cannot mask a new fault.
                if (cw[CW_FRESET] && !s_q.freset_prev) begin
                    s_d.state      = ST_SW_DIS;
                    s_d.fault_code = FAULT_NONE;
                end
            end
            default: s_d.state = ST_NOT_READY;
        endcase

        s_d.status = status_of(s_d.state, supply_present);
        s_d.contactor = s_q.ctrl[CTRL_SUPPLY+:2] == SUP_CONTACTOR
                        && (s_d.state == ST_SW_ON || s_d.state == ST_OP_EN);
        s_d.run = s_d.state == ST_OP_EN && ref_nonzero;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q             <= '0;
            s_q.ctrl        <= CTRL_RST;
            s_q.timeout     <= TIMEOUT_RST;
            s_q.state       <= ST_NOT_READY;
            s_q.fault_code  <= FAULT_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    dscs_chan_store #(
        .N_CH  (NUM_CH),
        .N_PAR (NUM_PAR)
    ) u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (chan)
    );

    assign pready               = s_q.pready;
    assign prdata               = s_q.prdata;
    assign pslverr              = s_q.pslverr;
    assign line_contactor_close = s_q.contactor;
    assign motor_run            = s_q.run;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_switch_on_req;
        s_q.state == ST_READY && is_switch_on(cw) && s_q.ctrl[CTRL_SUPPLY+:2] == SUP_CONTACTOR;
    endsequence

    sequence seq_loss_expired;
        s_q.state == ST_SW_ON && !supply_present && s_q.loss_ms >= s_q.timeout;
    endsequence

    a_ready_code: assert property (
        s_q.state == ST_READY |-> (s_q.status & STATUS_MASK) == ST_READY_CODE)
        else $error("Ready state shows a wrong masked status.");

    a_open_code: assert property (
        s_q.state == ST_OP_EN |-> (s_q.status & STATUS_MASK) == ST_OPEN_CODE)
        else $error("Operation enabled shows a wrong masked status.");

    a_volt_status: assert property (
        s_q.state == ST_READY && $past(s_q.state) == ST_READY
        |-> s_q.status[7:0] == ($past(supply_present) ? 8'h31 : 8'h21))
        else $error("Ready status does not follow supply presence.");

    a_enable_direct: assert property (
        s_q.state == ST_READY && is_enable(cw) |=> s_q.state == ST_OP_EN)
        else $error("Enable operation from ready not taken.");

    a_shutdown_ready: assert property (
        s_q.state == ST_SW_DIS && is_shutdown(cw) |=> s_q.state == ST_READY ##1 s_q.status[SW_READY])
        else $error("Shutdown did not reach ready.");

    a_run_ref: assert property (
        motor_run |-> s_q.state == ST_OP_EN && $past(ref_nonzero))
        else $error("Motor runs without a nonzero reference.");

    a_contactor_close: assert property (
        seq_switch_on_req |=> s_q.state == ST_SW_ON && line_contactor_close)
        else $error("Switch-on did not close the line contactor.");

    a_mains_fault: assert property (
        seq_loss_expired |=> s_q.state == ST_FAULT && s_q.fault_code == MAINS_LOSS_FAULT
        && s_q.status[SW_FAULT])
        else $error("Mains loss timeout did not raise the fault.");

    a_loss_clear: assert property (
        supply_present || s_q.state != ST_SW_ON |=> s_q.loss_ms == 16'h0000)
        else $error("Mains timeout counter not cleared.");

    a_combined_same: assert property (
        s_q.ctrl[CTRL_PROF+:2] == PROF_COMBINED |-> chan.cmd_ch == chan.ref_ch)
        else $error("Combined mode split the channels.");

    a_split_indep: assert property (
        split && !sw_cmd |-> chan.cmd_ch == s_q.ctrl[CTRL_CMD1+:3])
        else $error("Split command channel follows the reference switch.");

    a_apb_answer: assert property (
        setup |=> pready ##1 !pready)
        else $error("APB access phase not answered in one cycle.");

endmodule : dscs_top

// file: include/dscs_chan_if.sv
// Link between the sequencer and the per-channel parameter store.
`timescale 1ns/1ps
interface dscs_chan_if;
    logic        wr_en;
    logic [2:0]  wr_ch;
    logic [2:0]  wr_par;
    logic [15:0] wr_data;
    logic [2:0]  rd_ch;
    logic [2:0]  rd_par;
    logic [15:0] rd_data;
    logic [2:0]  cmd_ch;
    logic [2:0]  ref_ch;
    logic [15:0] act_cmd;
    logic [15:0] act_ext;
    logic [15:0] act_spd;
    logic [15:0] act_frq;
    logic [15:0] act_pid;
    logic [15:0] act_mul;

    modport ctrl (output wr_en, wr_ch, wr_par, wr_data, rd_ch, rd_par, cmd_ch, ref_ch,
                  input rd_data, act_cmd, act_ext, act_spd, act_frq, act_pid, act_mul);
    modport store (input wr_en, wr_ch, wr_par, wr_data, rd_ch, rd_par, cmd_ch, ref_ch,
                   output rd_data, act_cmd, act_ext, act_spd, act_frq, act_pid, act_mul);
endinterface : dscs_chan_if

// file: include/dscs_pkg.sv
// Shared constants and types for the drive start sequence and channel select block.
package dscs_pkg;

    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_TICK_NS    = 1000000;
    localparam int MS_TICK_CYC   = (MS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int NUM_CH  = 6;
    localparam int NUM_PAR = 6;
    localparam int WORD_W  = 16;

    localparam logic [2:0] CH_TERMINAL   = 3'h0;
    localparam logic [2:0] CH_HMI        = 3'h1;
    localparam logic [2:0] CH_MODBUS     = 3'h2;
    localparam logic [2:0] CH_CANOPEN    = 3'h3;
    localparam logic [2:0] CH_NETCARD    = 3'h4;
    localparam logic [2:0] CH_APPCARD    = 3'h5;
    localparam logic [2:0] BLK_MODBUS_P2 = 3'h6;

    localparam logic [2:0] PAR_CMD  = 3'h0;
    localparam logic [2:0] PAR_EXT  = 3'h1;
    localparam logic [2:0] PAR_SPD  = 3'h2;
    localparam logic [2:0] PAR_FRQ  = 3'h3;
    localparam logic [2:0] PAR_PID  = 3'h4;
    localparam logic [2:0] PAR_MUL  = 3'h5;

    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_TIMEOUT = 12'h004;
    localparam logic [11:0] REG_STATUS  = 12'h008;
    localparam logic [11:0] REG_FAULT   = 12'h00C;
    localparam logic [11:0] REG_ACT_CMD = 12'h010;
    localparam logic [11:0] REG_ACT_EXT = 12'h014;
    localparam logic [11:0] REG_ACT_SPD = 12'h018;
    localparam logic [11:0] REG_ACT_FRQ = 12'h01C;
    localparam logic [11:0] REG_ACT_PID = 12'h020;
    localparam logic [11:0] REG_ACT_MUL = 12'h024;
    localparam logic [11:0] REG_ACT_SEL = 12'h028;
    localparam logic [3:0]  CHAN_PAGE   = 4'h1;

    localparam int CTRL_W       = 18;
    localparam int CTRL_PROF    = 0;
    localparam int CTRL_SUPPLY  = 2;
    localparam int CTRL_CMD1    = 4;
    localparam int CTRL_CMD2    = 7;
    localparam int CTRL_REF1    = 10;
    localparam int CTRL_REF2    = 13;
    localparam int CTRL_CMD_SW  = 16;
    localparam int CTRL_REF_SW  = 17;
    localparam logic [17:0] CTRL_RST = 18'h00000;

    localparam logic [1:0] PROF_COMBINED = 2'h0;
    localparam logic [1:0] PROF_SPLIT    = 2'h1;
    localparam logic [1:0] PROF_IO       = 2'h2;

    localparam logic [1:0] SUP_SHARED    = 2'h0;
    localparam logic [1:0] SUP_SEPARATE  = 2'h1;
    localparam logic [1:0] SUP_CONTACTOR = 2'h2;

    localparam int CW_SWITCH_ON = 0;
    localparam int CW_EN_VOLT   = 1;
    localparam int CW_QSTOP     = 2;
    localparam int CW_EN_OP     = 3;
    localparam int CW_FRESET    = 7;

    localparam int SW_READY = 0;
    localparam int SW_SWON  = 1;
    localparam int SW_OPEN  = 2;
    localparam int SW_FAULT = 3;
    localparam int SW_VOLT  = 4;
    localparam int SW_QSTOP = 5;
    localparam int SW_SWDIS = 6;
    localparam logic [15:0] STATUS_MASK   = 16'h006F;
    localparam logic [15:0] ST_READY_CODE = 16'h0021;
    localparam logic [15:0] ST_OPEN_CODE  = 16'h0027;

    localparam logic [7:0]  FAULT_NONE       = 8'h00;
    localparam logic [7:0]  MAINS_LOSS_FAULT = 8'h01;
    localparam logic [15:0] TIMEOUT_RST      = 16'h0064;

    typedef enum logic [5:0] {
        ST_NOT_READY = 6'h01,
        ST_SW_DIS    = 6'h02,
        ST_READY     = 6'h04,
        ST_SW_ON     = 6'h08,
        ST_OP_EN     = 6'h10,
        ST_FAULT     = 6'h20
    } dscs_state_t;

endpackage : dscs_pkg

// file: testbench/drive_start_sequence_channel_select_bench.sv
// Self-checking bench for the start sequencer and channel selector.
`timescale 1ns/1ps
module drive_start_sequence_channel_select_bench;
    import dscs_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, supply_present, line_contactor_close, motor_run;
    logic        term_cmd_switch = 0, term_ref_switch = 0, mains_on = 1, use_contactor = 0;
    logic [19:0] lfsr_q = 20'h14FFD;
    logic [32:0] exp_q[$], msk_q[$];
    logic [15:0] mem [6][6];
    int          miscompares = 0, check_count = 0, cyc = 0;

    dscs_top #(.MS_TICK_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .supply_present(supply_present), .term_cmd_switch(term_cmd_switch), .term_ref_switch(term_ref_switch),
        .line_contactor_close(line_contactor_close), .motor_run(motor_run));
    dscs_supply_model sup_u (.pclk(pclk), .presetn(presetn), .mains_on(mains_on), .use_contactor(use_contactor),
        .contactor_close(line_contactor_close), .supply_present(supply_present));

    always #12.5 pclk = ~pclk;

    function automatic logic [19:0] lfsr_next(logic [19:0] s);
        return {s[18:0], s[19] ^ s[16]};
    endfunction : lfsr_next
    function automatic logic [11:0] ca(logic [2:0] ch, logic [2:0] par);
        return {CHAN_PAGE, ch, par, 2'h0};
    endfunction : ca
    function automatic logic [31:0] ctl(logic [1:0] prof, logic [1:0] sup);
        return {16'h0, 3'h4, 3'h2, 3'h3, 3'h2, sup, prof};
    endfunction : ctl
    task automatic cmp(string what, logic [32:0] e, logic [32:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask : cmp
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e, logic [32:0] m);
        @(posedge pclk);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(logic [11:0] a, logic [31:0] d, logic err = 1'b0);
        xfer(1'b1, a, d, {err, 32'h0}, 33'h1_0000_0000);
    endtask : wr
    task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFFFFFF);
        xfer(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
    endtask : rd
    task automatic cw(logic [15:0] v);
        wr(ca(CH_MODBUS, PAR_CMD), {16'h0, v});
    endtask : cw
    task automatic lvl(string what, logic e, ref logic g);
        repeat (2) @(posedge pclk);
        cmp(what, {32'h0, e}, {32'h0, g});
    endtask : lvl
    task automatic close_out;
        $display("compares %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // The monitor owns the queue head; the driver only appends.
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            cmp($sformatf("apb %h", paddr), exp_q[0], {pslverr, prdata} & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        logic [1:0] pf;
        logic       cs, rs;
        logic [2:0] cc, rc;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_CTRL, 32'h0);
        rd(REG_TIMEOUT, 32'h64);
        rd(REG_STATUS, 32'h50, 32'h7F);
        xfer(1'b0, 12'h300, 32'h0, {1'b1, 32'h0}, {1'b1, 32'hFFFFFFFF});
        wr(REG_STATUS, 32'h1, 1'b1);
        wr(REG_TIMEOUT, 32'h2);
        wr(REG_CTRL, ctl(PROF_COMBINED, SUP_SHARED));
        cw(16'h0006);
        rd(REG_STATUS, 32'h21, 32'h6F);
        cw(16'h000F);
        rd(REG_STATUS, 32'h27, 32'h6F);
        lvl("motor_run", 1'b0, motor_run);
        wr(ca(BLK_MODBUS_P2, PAR_FRQ), 32'h1F4);
        lvl("motor_run", 1'b1, motor_run);
        rd(ca(CH_MODBUS, PAR_FRQ), 32'h1F4);
        rd(REG_ACT_FRQ, 32'h1F4);
        cw(16'h0000);
        mains_on <= 1'b0;
        wr(REG_CTRL, ctl(PROF_COMBINED, SUP_SEPARATE));
        cw(16'h0006);
        rd(REG_STATUS, 32'h21, 32'h7F);
        mains_on <= 1'b1;
        rd(REG_STATUS, 32'h31, 32'h7F);
        cw(16'h0007);
        rd(REG_STATUS, 32'h33, 32'h7F);
        mains_on <= 1'b0;
        repeat (30) @(posedge pclk);
        rd(REG_FAULT, {24'h0, MAINS_LOSS_FAULT});
        rd(REG_STATUS, 32'h08, 32'h6F);
        cw(16'h0000);
        cw(16'h0080);
        rd(REG_STATUS, 32'h40, 32'h6F);
        mains_on <= 1'b1;
        use_contactor <= 1'b1;
        wr(REG_CTRL, ctl(PROF_COMBINED, SUP_CONTACTOR));
        cw(16'h0006);
        lvl("contactor", 1'b0, line_contactor_close);
        rd(REG_STATUS, 32'h21, 32'h7F);
        cw(16'h0007);
        lvl("contactor", 1'b1, line_contactor_close);
        // The contactor model takes three cycles to apply the supply.
        repeat (3) @(posedge pclk);
        rd(REG_STATUS, 32'h33, 32'h7F);
        cw(16'h000F);
        rd(REG_STATUS, 32'h27, 32'h6F);
        lvl("motor_run", 1'b1, motor_run);
        for (int c = 0; c < 6; c++) begin
            for (int p = 0; p < 6; p++) begin
                lfsr_q = lfsr_next(lfsr_q);
                mem[c][p] = lfsr_q[15:0];
                wr(ca(3'(c), 3'(p)), {16'hFFFF, lfsr_q[15:0]});
                rd(ca(3'(c), 3'(p)), {16'h0, mem[c][p]});
            end
        end
        for (int i = 0; i < 9; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            pf = 2'(i % 3);
            term_cmd_switch <= lfsr_q[0];
            term_ref_switch <= lfsr_q[1];
            wr(REG_CTRL, {14'h0, lfsr_q[3:2], 3'h5, 3'h1, 3'h3, 3'h0, 2'h0, pf});
            cs = lfsr_q[0] | lfsr_q[2];
            rs = lfsr_q[1] | lfsr_q[3];
            rc = rs ? 3'h5 : 3'h1;
            cc = (pf == PROF_COMBINED) ? rc : (cs ? 3'h3 : 3'h0);
            rd(REG_ACT_SEL, {26'h0, rc, cc});
            rd(REG_ACT_CMD, {16'h0, mem[cc][0]});
            rd(REG_ACT_FRQ, {16'h0, mem[rc][3]});
            rd(REG_ACT_PID, {16'h0, mem[rc][4]});
        end
        close_out();
    end
endmodule : drive_start_sequence_channel_select_bench

// file: testbench/dscs_supply_model.sv
// Model of the mains supply and line contactor facing the drive.
`timescale 1ns/1ps
module dscs_supply_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic mains_on,
    input  wire logic use_contactor,
    input  wire logic contactor_close,
    output logic      supply_present
);
    logic [2:0] close_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            close_q <= 3'h0;
        end else begin
            close_q <= {close_q[1:0], contactor_close};
        end
    end
    // contactor applies supply.
    // A slow contactor makes the drive wait, as a real one would.
    assign supply_present = mains_on & (!use_contactor | close_q[2]);
endmodule : dscs_supply_model
